// file: core/serial_pkg.sv
`default_nettype none

package serial_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0C;

  // control register fields
  localparam int C_RX_EN     = 0;
  localparam int C_TX_EN     = 1;
  localparam int C_STANDBY   = 2;
  localparam int C_BREAK     = 3;
  localparam int C_NINE      = 4;
  localparam int C_WAKE_ADDR = 5;
  localparam int C_TIE       = 6;
  localparam int C_TX_COMPLETE_IRQ_ENABLE      = 7;
  localparam int C_RIE       = 8;
  localparam int C_ILIE      = 9;
  localparam int CTRL_W      = 10;
  localparam logic [9:0] CTRL_RST = 10'h000;

  // status register fields
  localparam int S_TX_BUFFER_EMPTY_FLAG = 0;
  localparam int S_TC   = 1;
  localparam int S_RX_BUFFER_FULL_FLAG = 2;
  localparam int S_IDLE = 3;
  localparam int S_OVR  = 4;
  localparam int S_NF   = 5;
  localparam int S_FE   = 6;

  // baud select: 32 rates, oversample period is select plus one cycles
  localparam int BAUD_W = 5;
  localparam logic [4:0] BAUD_RST = 5'h00;

  // frame lengths in bits, idle lengths in oversample ticks
  localparam logic [3:0] BITS_8    = 4'hA;
  localparam logic [3:0] BITS_9    = 4'hB;
  localparam logic [7:0] IDLE_RT_8 = 8'hA0;
  localparam logic [7:0] IDLE_RT_9 = 8'hB0;

  // oversample positions inside one bit, 0 stands for the first tick
  localparam logic [3:0] POS_VER1 = 4'h2;
  localparam logic [3:0] POS_VER2 = 4'h4;
  localparam logic [3:0] POS_VER3 = 4'h6;
  localparam logic [3:0] POS_S1   = 4'h7;
  localparam logic [3:0] POS_S2   = 4'h8;
  localparam logic [3:0] POS_S3   = 4'h9;
  localparam logic [3:0] POS_LAST = 4'hF;

  // buffer value reported for a received break
  localparam logic [8:0] BREAK_CODE = 9'h03B;

  typedef enum logic [0:0] {
    RX_HUNT  = 1'b0,
    RX_FRAME = 1'b1
  } rx_state_e;

endpackage

`default_nettype wire

// file: core/async_serial_transceiver.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - thirty-two baud rates, one setting shared by transmitter and receiver
// - data write starts sending; load into shifter sets buffer-empty flag
// - shifter loads only on a transmit bit tick
// - bits go out and come in least significant first
// - finish with nothing pending sets complete flag and its interrupt
// - disabled transmitter sets complete flag once shifter has emptied
// - disabling mid-character finishes it before releasing the pin
// - received byte moves to buffer on rx tick, sets full flag
// - idle flag with its enable requests an interrupt
// - idle flag needs one valid character since last clear
// - frame: high idle, low start, eight or nine data, high stop
// - break is line low for a whole frame, sent or received
// - standby blocks receive flags, idle included, except for an address wakeup character; idle detection still runs for wakeup
// - standby cleared by wakeup condition or by software write
// - idle wakeup after ten or eleven high bit times
// - address wakeup when character top data bit is one
// - receiver samples at sixteen times the baud rate
// - receiver bit timing aligns to each start bit
// - majority of samples eight, nine, ten; disagreement sets noise
// - three verify samples, two lows confirm start, any high is noise
// - non-break framing error acts as stop with artificial start
// - break sets full and framing with value 03B, waits for high
// - enabling transmitter first sends ten or eleven ones
// - length bit one selects nine data bits, zero selects eight
// - send-break sends zero groups; clearing it ends with a one unless data is pending, which starts with its start bit
module async_serial_transceiver #(
  parameter int AW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          serial_rx_pin,
  output logic               serial_tx_pin,
  output logic               serial_tx_oe_n,
  output logic               irq
);

  // majority of three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // three samples that do not all agree
  function automatic logic split3(input logic [2:0] v);
    split3 = ~((&v) | ~(|v));
  endfunction

  // bus and register state
  logic [31:0]                   prdata_r,    prdata_nxt;
  logic                          pready_r,    pready_nxt;
  logic                          pslverr_r,   pslverr_nxt;
  logic [serial_pkg::CTRL_W-1:0] ctrl_r,      ctrl_nxt;
  logic [serial_pkg::BAUD_W-1:0] baud_r,      baud_nxt;
  logic [8:0]                    tx_data_r,   tx_data_nxt;
  logic [8:0]                    rx_data_r,   rx_data_nxt;
  logic                          tx_buffer_empty_flag_r,      tx_buffer_empty_flag_nxt;
  logic                          tc_r,        tc_nxt;
  logic                          rx_buffer_full_flag_r,      rx_buffer_full_flag_nxt;
  logic                          idle_r,      idle_nxt;
  logic                          ovr_r,       ovr_nxt;
  logic                          nf_r,        nf_nxt;
  logic                          fe_r,        fe_nxt;
  logic                          seen_r,      seen_nxt;
  logic                          irq_r,       irq_nxt;
  // baud generator and transmitter state
  logic [serial_pkg::BAUD_W-1:0] div_r,       div_nxt;
  logic [3:0]                    tx_rt_r,     tx_rt_nxt;
  logic [10:0]                   tx_sh_r,     tx_sh_nxt;
  logic [3:0]                    tx_left_r,   tx_left_nxt;
  logic                          tx_busy_r,   tx_busy_nxt;
  logic                          pre_pend_r,  pre_pend_nxt;
  logic                          txd_r,       txd_nxt;
  logic                          oe_n_r,      oe_n_nxt;
  // receiver state
  serial_pkg::rx_state_e         rx_st_r,     rx_st_nxt;
  logic [3:0]                    rx_pos_r,    rx_pos_nxt;
  logic [3:0]                    rx_bit_r,    rx_bit_nxt;
  logic [8:0]                    rx_sh_r,     rx_sh_nxt;
  logic [2:0]                    smp_r,       smp_nxt;
  logic                          noise_r,     noise_nxt;
  logic                          zero_r,      zero_nxt;
  logic                          brk_r,       brk_nxt;
  logic                          armed_r,     armed_nxt;
  logic [7:0]                    idle_cnt_r,  idle_cnt_nxt;
  logic                          idle_done_r, idle_done_nxt;
  logic                          valid_r,     valid_nxt;

  // helper terms
  logic       rt_tick;
  logic       bit_tick;
  logic       nine;
  logic [3:0] nbits;
  logic [7:0] idle_len;
  logic       acc;
  logic [7:0] addr;
  logic [2:0] cur3;
  logic       vote;
  logic [8:0] chr;
  logic       fe_now;
  logic       brk_now;
  logic       wake;
  logic       allow;
  logic       idle_ev;

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign serial_tx_pin  = txd_r;
  assign serial_tx_oe_n = oe_n_r;
  assign irq            = irq_r;

  // shared rate: one oversample tick every baud_r+1 cycles
  // shared rate select
  assign rt_tick  = (div_r == baud_r);
  assign bit_tick = rt_tick & (tx_rt_r == serial_pkg::POS_LAST);
  assign nine     = ctrl_r[serial_pkg::C_NINE];
  assign nbits    = nine ? serial_pkg::BITS_9 : serial_pkg::BITS_8;
  assign idle_len = nine ? serial_pkg::IDLE_RT_9 : serial_pkg::IDLE_RT_8;
  assign acc      = psel & penable & pready_r;
  assign addr     = 8'(paddr);

  // next-state logic for bus, transmitter and receiver
  always_comb begin
    prdata_nxt    = prdata_r;
    pready_nxt    = psel & ~penable;
    pslverr_nxt   = 1'b0;
    ctrl_nxt      = ctrl_r;
    baud_nxt      = baud_r;
    tx_data_nxt   = tx_data_r;
    rx_data_nxt   = rx_data_r;
    tx_buffer_empty_flag_nxt      = tx_buffer_empty_flag_r;
    tc_nxt        = tc_r;
    rx_buffer_full_flag_nxt      = rx_buffer_full_flag_r;
    idle_nxt      = idle_r;
    ovr_nxt       = ovr_r;
    nf_nxt        = nf_r;
    fe_nxt        = fe_r;
    seen_nxt      = seen_r;
    div_nxt       = rt_tick ? 5'h00 : div_r + 5'h01;
    tx_rt_nxt     = rt_tick ? tx_rt_r + 4'h1 : tx_rt_r;
    tx_sh_nxt     = tx_sh_r;
    tx_left_nxt   = tx_left_r;
    tx_busy_nxt   = tx_busy_r;
    pre_pend_nxt  = pre_pend_r;
    txd_nxt       = txd_r;
    oe_n_nxt      = oe_n_r;
    rx_st_nxt     = rx_st_r;
    rx_pos_nxt    = rx_pos_r;
    rx_bit_nxt    = rx_bit_r;
    rx_sh_nxt     = rx_sh_r;
    smp_nxt       = smp_r;
    noise_nxt     = noise_r;
    zero_nxt      = zero_r;
    brk_nxt       = brk_r;
    armed_nxt     = armed_r;
    idle_cnt_nxt  = idle_cnt_r;
    idle_done_nxt = idle_done_r;
    valid_nxt     = valid_r;
    cur3          = {smp_r[1:0], serial_rx_pin};
    vote          = maj3(cur3);
    chr           = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
    fe_now        = 1'b0;
    brk_now       = 1'b0;
    wake          = 1'b0;
    allow         = 1'b0;
    idle_ev       = 1'b0;

    // setup phase: decode and latch read data, answer next cycle
    if (psel & ~penable) begin
      unique case (addr)
        serial_pkg::OFS_DATA: prdata_nxt = {23'h000000, rx_data_r};
        serial_pkg::OFS_CTRL: prdata_nxt = {22'h000000, ctrl_r};
        serial_pkg::OFS_STAT:
          prdata_nxt = {25'h0000000, fe_r, nf_r, ovr_r, idle_r,
                        rx_buffer_full_flag_r, tc_r, tx_buffer_empty_flag_r};
        serial_pkg::OFS_BAUD: prdata_nxt = {27'h0000000, baud_r};
        default: begin
          prdata_nxt  = 32'h00000000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end

    // access edge: writes land and read side effects happen here
    if (acc & pwrite) begin
      unique case (addr)
        serial_pkg::OFS_DATA: begin
          tx_data_nxt = pwdata[8:0];
          tx_buffer_empty_flag_nxt    = 1'b0;
          tc_nxt      = 1'b0;
        end
        serial_pkg::OFS_CTRL: begin
          ctrl_nxt = pwdata[serial_pkg::CTRL_W-1:0];
          if (~ctrl_r[serial_pkg::C_TX_EN] & pwdata[serial_pkg::C_TX_EN]) begin
            pre_pend_nxt = 1'b1;
          end
        end
        serial_pkg::OFS_BAUD: baud_nxt = pwdata[serial_pkg::BAUD_W-1:0];
        default: ;
      endcase
    end else if (acc) begin
      // rx flags clear by a status read followed by a data read
      if (addr == serial_pkg::OFS_STAT) begin
        seen_nxt = 1'b1;
      end else if (addr == serial_pkg::OFS_DATA && seen_r) begin
        rx_buffer_full_flag_nxt = 1'b0;
        idle_nxt = 1'b0;
        ovr_nxt  = 1'b0;
        nf_nxt   = 1'b0;
        fe_nxt   = 1'b0;
        seen_nxt = 1'b0;
      end
    end

    // transmitter: one decision per bit time, loads only on the bit tick
    // load in step
    if (bit_tick) begin
      if (tx_left_r != 4'h0) begin
        txd_nxt     = tx_sh_r[0];
        tx_sh_nxt   = {1'b1, tx_sh_r[10:1]};
        tx_left_nxt = tx_left_r - 4'h1;
      end else if (ctrl_r[serial_pkg::C_TX_EN] & pre_pend_r) begin
        txd_nxt      = 1'b1;
        tx_sh_nxt    = 11'h7FF;
        tx_left_nxt  = nbits - 4'h1;
        tx_busy_nxt  = 1'b1;
        pre_pend_nxt = 1'b0;
        oe_n_nxt     = 1'b0;
      end else if (ctrl_r[serial_pkg::C_TX_EN] &
                   ctrl_r[serial_pkg::C_BREAK]) begin
        txd_nxt     = 1'b0;
        tx_sh_nxt   = 11'h000;
        tx_left_nxt = nbits - 4'h1;
        tx_busy_nxt = 1'b1;
        oe_n_nxt    = 1'b0;
      end else if (ctrl_r[serial_pkg::C_TX_EN] & ~tx_buffer_empty_flag_r) begin
        txd_nxt     = 1'b0;
        tx_sh_nxt   = nine ? {2'b11, tx_data_r} :
                             {3'b111, tx_data_r[7:0]};
        tx_left_nxt = nbits - 4'h1;
        tx_busy_nxt = 1'b1;
        tx_buffer_empty_flag_nxt    = 1'b1;
        oe_n_nxt    = 1'b0;
      end else begin
        // line returns high; break end shows as this one
        txd_nxt = 1'b1;
        if (tx_busy_r) begin
          tc_nxt      = 1'b1;
          tx_busy_nxt = 1'b0;
        end
        if (~ctrl_r[serial_pkg::C_TX_EN]) begin
          oe_n_nxt = 1'b1;
        end
      end
    end

    // idle line detection runs on oversample ticks while hunting
    if (rt_tick) begin
      if (rx_st_r == serial_pkg::RX_FRAME || ~serial_rx_pin) begin
        idle_cnt_nxt  = 8'h00;
        idle_done_nxt = 1'b0;
      end else if (idle_cnt_r != idle_len) begin
        idle_cnt_nxt = idle_cnt_r + 8'h01;
      end else if (~idle_done_r) begin
        idle_ev       = 1'b1;
        idle_done_nxt = 1'b1;
      end
    end
    if (idle_ev) begin
      if (ctrl_r[serial_pkg::C_STANDBY]) begin
        if (~ctrl_r[serial_pkg::C_WAKE_ADDR]) begin
          ctrl_nxt[serial_pkg::C_STANDBY] = 1'b0;
        end
      end else if (valid_r) begin
        idle_nxt  = 1'b1;
        valid_nxt = 1'b0;
      end
    end

    // receiver bit engine on oversample ticks
    if (~ctrl_r[serial_pkg::C_RX_EN]) begin
      rx_st_nxt = serial_pkg::RX_HUNT;
    end else if (rt_tick) begin
      unique case (rx_st_r)
        serial_pkg::RX_HUNT: begin
          if (serial_rx_pin) begin
            armed_nxt = 1'b1;
          end else if (armed_r) begin
            rx_st_nxt  = serial_pkg::RX_FRAME;
            rx_pos_nxt = 4'h1;
            rx_bit_nxt = 4'h0;
            noise_nxt  = 1'b0;
            zero_nxt   = 1'b1;
            smp_nxt    = 3'h0;
          end
        end
        serial_pkg::RX_FRAME: begin
          rx_pos_nxt = rx_pos_r + 4'h1;
          if (rx_bit_r == 4'h0 && (rx_pos_r == serial_pkg::POS_VER1 ||
                                   rx_pos_r == serial_pkg::POS_VER2)) begin
            smp_nxt = cur3;
          end
          if (rx_bit_r == 4'h0 && rx_pos_r == serial_pkg::POS_VER3) begin
            if (vote) begin
              rx_st_nxt = serial_pkg::RX_HUNT;
            end else if (|cur3) begin
              noise_nxt = 1'b1;
            end
          end
          if (rx_pos_r == serial_pkg::POS_S1 ||
              rx_pos_r == serial_pkg::POS_S2) begin
            smp_nxt = cur3;
          end
          if (rx_pos_r == serial_pkg::POS_S3) begin
            if (split3(cur3)) begin
              noise_nxt = 1'b1;
            end
            if (rx_bit_r != 4'h0 && rx_bit_r != nbits - 4'h1) begin
              rx_sh_nxt = {vote, rx_sh_r[8:1]};
              zero_nxt  = zero_r & ~vote;
            end
            if (rx_bit_r == nbits - 4'h1) begin
              fe_now  = ~vote;
              brk_now = ~vote & zero_r;
              brk_nxt = brk_now;
              if (brk_now) begin
                chr = serial_pkg::BREAK_CODE;
              end
              wake  = ctrl_r[serial_pkg::C_STANDBY] &
                      ctrl_r[serial_pkg::C_WAKE_ADDR] &
                      (nine ? chr[8] : chr[7]);
              allow = ~ctrl_r[serial_pkg::C_STANDBY] | wake;
              if (wake) begin
                ctrl_nxt[serial_pkg::C_STANDBY] = 1'b0;
              end
              if (allow) begin
                valid_nxt = ~fe_now;
                if (rx_buffer_full_flag_r) begin
                  ovr_nxt = 1'b1;
                end else begin
                  rx_data_nxt = chr;
                  rx_buffer_full_flag_nxt    = 1'b1;
                end
                if (noise_nxt) begin
                  nf_nxt = 1'b1;
                end
                if (fe_now) begin
                  fe_nxt = 1'b1;
                end
              end
            end
          end
          if (rx_pos_r == serial_pkg::POS_LAST) begin
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_r == nbits - 4'h1) begin
              // break waits for a high line
              rx_st_nxt = serial_pkg::RX_HUNT;
              armed_nxt = ~brk_r;
            end
          end
        end
      endcase
    end

    // single request line built from flags and their enables
    // transmit, complete, idle and receive interrupts
    irq_nxt = (tx_buffer_empty_flag_r & ctrl_r[serial_pkg::C_TIE]) |
              (tc_r & ctrl_r[serial_pkg::C_TX_COMPLETE_IRQ_ENABLE]) |
              (idle_r & ctrl_r[serial_pkg::C_ILIE]) |
              ((rx_buffer_full_flag_r | ovr_r) & ctrl_r[serial_pkg::C_RIE] &
               ctrl_r[serial_pkg::C_RX_EN]);
  end

  // registers; tx flags come out of reset set, as after power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (~presetn) begin
      prdata_r    <= 32'h00000000;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      ctrl_r      <= serial_pkg::CTRL_RST;
      baud_r      <= serial_pkg::BAUD_RST;
      tx_data_r   <= 9'h000;
      rx_data_r   <= 9'h000;
      tx_buffer_empty_flag_r      <= 1'b1;
      tc_r        <= 1'b1;
      rx_buffer_full_flag_r      <= 1'b0;
      idle_r      <= 1'b0;
      ovr_r       <= 1'b0;
      nf_r        <= 1'b0;
      fe_r        <= 1'b0;
      seen_r      <= 1'b0;
      irq_r       <= 1'b0;
      div_r       <= 5'h00;
      tx_rt_r     <= 4'h0;
      tx_sh_r     <= 11'h7FF;
      tx_left_r   <= 4'h0;
      tx_busy_r   <= 1'b0;
      pre_pend_r  <= 1'b0;
      txd_r       <= 1'b1;
      oe_n_r      <= 1'b1;
      rx_st_r     <= serial_pkg::RX_HUNT;
      rx_pos_r    <= 4'h0;
      rx_bit_r    <= 4'h0;
      rx_sh_r     <= 9'h000;
      smp_r       <= 3'h0;
      noise_r     <= 1'b0;
      zero_r      <= 1'b0;
      brk_r       <= 1'b0;
      armed_r     <= 1'b0;
      idle_cnt_r  <= 8'h00;
      idle_done_r <= 1'b0;
      valid_r     <= 1'b0;
    end else begin
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      ctrl_r      <= ctrl_nxt;
      baud_r      <= baud_nxt;
      tx_data_r   <= tx_data_nxt;
      rx_data_r   <= rx_data_nxt;
      tx_buffer_empty_flag_r      <= tx_buffer_empty_flag_nxt;
      tc_r        <= tc_nxt;
      rx_buffer_full_flag_r      <= rx_buffer_full_flag_nxt;
      idle_r      <= idle_nxt;
      ovr_r       <= ovr_nxt;
      nf_r        <= nf_nxt;
      fe_r        <= fe_nxt;
      seen_r      <= seen_nxt;
      irq_r       <= irq_nxt;
      div_r       <= div_nxt;
      tx_rt_r     <= tx_rt_nxt;
      tx_sh_r     <= tx_sh_nxt;
      tx_left_r   <= tx_left_nxt;
      tx_busy_r   <= tx_busy_nxt;
      pre_pend_r  <= pre_pend_nxt;
      txd_r       <= txd_nxt;
      oe_n_r      <= oe_n_nxt;
      rx_st_r     <= rx_st_nxt;
      rx_pos_r    <= rx_pos_nxt;
      rx_bit_r    <= rx_bit_nxt;
      rx_sh_r     <= rx_sh_nxt;
      smp_r       <= smp_nxt;
      noise_r     <= noise_nxt;
      zero_r      <= zero_nxt;
      brk_r       <= brk_nxt;
      armed_r     <= armed_nxt;
      idle_cnt_r  <= idle_cnt_nxt;
      idle_done_r <= idle_done_nxt;
      valid_r     <= valid_nxt;
    end
  end

endmodule

`default_nettype wire

// file: bench/serial_properties.sv
`timescale 1ns/100ps
`default_nettype none

module serial_properties #(
  parameter int AW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          serial_tx_pin,
  input wire logic          serial_tx_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a bus transfer: setup, then exactly one answered access cycle
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; pready ##1 !pready; endsequence
  logic bad_addr;
  assign bad_addr = paddr > 8'h0C || paddr[1:0] != 2'h0;

  a_ready_after_setup: assert property (setup_s |=> answer_s)
    else $error("no single answer after setup");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  a_unmapped_err: assert property (psel && pready && bad_addr |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && pready && !bad_addr |-> !pslverr)
    else $error("mapped access refused");
  // no bit on the line is shorter than nine cycles
  a_start_hold: assert property ($fell(serial_tx_pin) |=> !serial_tx_pin[*8])
    else $error("low bit too short");
  a_stop_hold: assert property ($rose(serial_tx_pin) |=> serial_tx_pin[*8])
    else $error("high bit too short");
  a_preamble_ones: assert property ($fell(serial_tx_oe_n) |-> serial_tx_pin[*8])
    else $error("enable not followed by ones");
  a_release_high: assert property ($rose(serial_tx_oe_n) |-> serial_tx_pin)
    else $error("pin released mid character");
endmodule

bind async_serial_transceiver serial_properties #(.AW(AW)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_tx_pin(serial_tx_pin), .serial_tx_oe_n(serial_tx_oe_n));

`default_nettype wire

// file: bench/serial_peer.sv
`timescale 1ns/100ps
`default_nettype none

// remote sender at the fastest rate, sixteen cycles per bit
module serial_peer (
  input wire logic pclk,
  output logic     line
);
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (16) @(posedge pclk);
    end
    line <= 1'b1;
  endtask
  task automatic brk(input int nbits);
    line <= 1'b0;
    repeat (16 * nbits) @(posedge pclk);
    line <= 1'b1;
  endtask
endmodule

`default_nettype wire

// file: bench/async_serial_transceiver_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end

module async_serial_transceiver_test;
  localparam logic [7:0] DA = serial_pkg::OFS_DATA;
  localparam logic [7:0] CT = serial_pkg::OFS_CTRL;
  localparam logic [7:0] ST = serial_pkg::OFS_STAT;
  localparam logic [7:0] BD = serial_pkg::OFS_BAUD;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, rx_line, tx_pin, oe_n, irq;
  logic [7:0]  paddr = 8'h00, b, e8;
  logic [31:0] pwdata = 32'h0, prdata, rv, e32;
  int          n_errors = 0, compares = 0, seed = 32'heb02e679;
  logic [31:0] rq[$];
  logic [7:0]  tq[$];

  always #20 pclk = ~pclk;
  async_serial_transceiver DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_rx_pin(rx_line), .serial_tx_pin(tx_pin),
    .serial_tx_oe_n(oe_n), .irq(irq));
  serial_peer peer (.pclk(pclk), .line(rx_line));

  task automatic summarize;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tout;
    n_errors++;
    summarize();
  endtask
  // one transfer; an idle cycle first so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) tout();
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic poll(input int bi);
    int k;
    for (k = 0; k < 400 && rv[bi] !== 1'b1; k++) apb(1'b0, ST, 32'h0);
    if (k == 400) tout();
  endtask

  // read watcher: each answered read against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && rq.size() > 0) begin
      e32 = rq.pop_front();
      `CHK(prdata, e32)
    end
  // tx watcher: decode each frame mid-bit while the pin is driven
  initial forever begin
    @(negedge tx_pin);
    if (oe_n === 1'b0) begin
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge pclk);
        b[i] = tx_pin;
      end
      repeat (16) @(posedge pclk);
      e8 = tq.pop_front();
      `CHK({tx_pin, b}, {1'b1, e8})
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    tout();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(CT, 32'h0);
    rd(ST, 32'h3);
    rd(8'h10, 32'h0);
    e8 = 8'($random(seed));
    apb(1'b1, BD, {27'h0, e8[4:0]});
    rd(BD, {27'h0, e8[4:0]});
    apb(1'b1, BD, 32'h0);
    $display("register test done");
    // back-to-back bytes, each loaded on a bit tick
    apb(1'b1, CT, 32'h3);
    for (int i = 0; i < 3; i++) begin
      tq.push_back(8'($random(seed)));
      apb(1'b1, DA, {24'h0, tq[tq.size()-1]});
      rv = 32'h0;
      poll(0);
    end
    rv = 32'h0;
    poll(1);
    $display("transmit test done");
    e8 = 8'($random(seed));
    peer.send(e8, 1'b1);
    rd(ST, 32'h7);
    rd(DA, {24'h0, e8});
    peer.send(e8 | 8'h01, 1'b0);
    rd(ST, 32'h47);
    rd(DA, {24'h0, e8 | 8'h01});
    peer.brk(20);
    rd(ST, 32'h47);
    rd(DA, 32'h3B);
    $display("receive test done");
    apb(1'b1, CT, 32'h203);
    peer.send(e8, 1'b1);
    rd(ST, 32'h7);
    rd(DA, {24'h0, e8});
    repeat (200) @(posedge pclk);
    rd(ST, 32'hB);
    `CHK(irq, 1'b1)
    rd(DA, {24'h0, e8});
    repeat (200) @(posedge pclk);
    rd(ST, 32'h3);
    `CHK(irq, 1'b0)
    $display("idle test done");
    apb(1'b1, CT, 32'h27);
    peer.send(8'h12, 1'b1);
    rd(ST, 32'h3);
    rd(CT, 32'h27);
    peer.send(8'h85, 1'b1);
    rd(CT, 32'h23);
    // idle-line wakeup: a frame while asleep, then ten idle bits wake it
    apb(1'b1, CT, 32'h7);
    peer.send(8'h55, 1'b1);
    rd(CT, 32'h7);
    repeat (200) @(posedge pclk);
    rd(CT, 32'h3);
    // buffer still full from the address byte: overrun keeps old byte
    peer.send(8'h3C, 1'b1);
    rd(ST, 32'h17);
    rd(DA, 32'h85);
    $display("wakeup test done");
    // disable mid-character: frame still completes, then pin released
    tq.push_back(8'($random(seed)));
    apb(1'b1, DA, {24'h0, tq[tq.size()-1]});
    rv = 32'h0;
    poll(0);
    apb(1'b1, CT, 32'h1);
    rv = 32'h0;
    poll(1);
    `CHK(oe_n, 1'b1)
    // nine-bit: the peer's stop lands as bit eight, idle high as stop
    apb(1'b1, CT, 32'h11);
    peer.send(8'hA5, 1'b1);
    repeat (16) @(posedge pclk);
    rd(ST, 32'hF);
    rd(DA, 32'h1A5);
    $display("disable and nine-bit test done");
    summarize();
  end
endmodule

`default_nettype wire
